//--- design/vol_ctrl_pkg.sv
// shared constants for the serial volume control link and its two ends
package vol_ctrl_pkg;
  // system clock
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CLK_PERIOD_NS   = 5;
  // control word layout
  localparam int unsigned WORD_BITS       = 16;
  localparam int unsigned LEVEL_BITS      = 8;
  localparam int unsigned RIGHT_MSB       = 15;
  localparam int unsigned RIGHT_LSB       = 8;
  localparam int unsigned LEFT_MSB        = 7;
  localparam int unsigned LEFT_LSB        = 0;
  localparam logic [7:0]  SOFT_MUTE_CODE  = 8'h00;
  localparam logic [7:0]  UNITY_CODE      = 8'hC0;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  // zero crossings needed before a new level lands
  localparam logic [1:0]  ZC_NEEDED       = 2'h2;
  // timeouts and calibration, in their own unit, then in cycles
  localparam int unsigned ZC_TIMEOUT_MS   = 100;
  localparam int unsigned ZC_TIMEOUT_CYC  = ZC_TIMEOUT_MS * CLK_PER_MS;
  localparam int unsigned CAL_TIME_MS     = 2;
  localparam int unsigned CAL_TIME_CYC    = CAL_TIME_MS * CLK_PER_MS;
  localparam int unsigned MUTE_HOLD_MS    = 2;
  localparam int unsigned MUTE_HOLD_CYC   = MUTE_HOLD_MS * CLK_PER_MS;
  localparam int unsigned TIMER_BITS      = 25;
  // host shift clock: half period, rounded up to whole cycles
  localparam int unsigned SCLK_HALF_NS    = 80;
  localparam int unsigned SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_BITS        = 8;
  localparam logic [4:0]  BIT_COUNT_RESET = 5'h00;
  // synchroniser reset levels: {zc_l, zc_r, supply, mute_n, sdi, sclk, select_n}
  // mute resets low, as the host holds it, so no false mute edge follows reset
  localparam logic [6:0]  DEV_SYNC_RESET  = 7'h11;
  // device sequencing
  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_CAL,
    ST_RUN
  } dev_state_t;
  // host transfer sequencing
  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_LOW,
    H_HIGH,
    H_TAIL,
    H_GAP
  } host_state_t;
endpackage

//--- design/vol_link_if.sv
// four-wire serial link plus mute line between host and volume device
`timescale 1ns/100ps
interface vol_link_if;
  logic select_n;                 // transfer frame, low while shifting
  logic shift_clk;                // shift clock from host
  logic serial_data_in;           // host to device data
  logic mute_n;                   // hardware mute, low active
  logic serial_data_out;          // device data out value
  logic serial_data_out_oe_n;     // device drives when low
  logic serial_data_out_level;    // resolved wire level

  // released wire reads as pulled high
  assign serial_data_out_level = serial_data_out_oe_n ? 1'b1 : serial_data_out;

  modport host (
    output select_n,
    output shift_clk,
    output serial_data_in,
    output mute_n,
    input  serial_data_out_level
  );
  modport dev (
    input  select_n,
    input  shift_clk,
    input  serial_data_in,
    input  mute_n,
    output serial_data_out,
    output serial_data_out_oe_n
  );
endinterface

//--- design/sync_edge.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/100ps
module sync_edge #(
  parameter int unsigned      WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] async_in,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta_q;   // first stage, read only by the second
  logic [WIDTH-1:0] sync_q;   // second stage
  logic [WIDTH-1:0] prev_q;   // delayed copy for edges

  // synchroniser chain
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
      prev_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule

//--- design/vol_ctrl_device.sv
// device end: serial shift path, level latch, zero-cross apply, mute, calibration
`timescale 1ns/100ps
module vol_ctrl_device
  import vol_ctrl_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_CYC,
  parameter int unsigned CAL_CYCLES        = CAL_TIME_CYC
) (
  // clock and reset
  input  wire logic   clock_in,
  input  wire logic   resetn_in,
  // serial link
  vol_link_if.dev     link,
  // analog-side status
  input  wire logic   zero_cross_enable_in,
  input  wire logic   left_zero_cross_in,
  input  wire logic   right_zero_cross_in,
  input  wire logic   supply_ok_in,
  // applied channel state
  output logic [7:0]  left_output_code_out,
  output logic [7:0]  right_output_code_out,
  output logic        left_soft_mute_out,
  output logic        right_soft_mute_out,
  output logic        hard_mute_out,
  output logic        calibrating_out,
  output logic [15:0] volume_reg_out
);
  // synchronised pins
  logic [6:0] lvl;
  logic [6:0] rise;
  logic [6:0] fall;
  logic       sel_n;                 // select, synchronised
  logic       sdi;                   // data in, synchronised
  logic       ze;                    // zero-cross enable level
  logic       supply_ok;             // supply flag level
  logic       mute_req;              // hard mute wanted
  logic       zc_any;                // either channel crossed
  logic [1:0] zc_rise;               // {left, right} crossing pulses
  logic       shift_rise;            // sampling edge inside a frame
  logic       shift_fall;            // output edge inside a frame
  logic       latch;                 // select rising edge
  logic       zc_expired;            // level-change wait ran out
  logic       hm_expired;            // mute wait ran out

  // registers
  dev_state_t            state_q;    // power-up / calibration sequencing
  logic [15:0]           shift_q;    // 16-stage serial path
  logic [15:0]           vol_q;      // latched volume control register
  logic                  sdo_q;      // serial output bit
  logic                  oe_n_q;     // serial output enable, low drives
  logic [1:0]            pend_q;     // {left, right} level change pending
  logic [1:0]            zc_cnt_q [2];
  logic [7:0]            code_q [2]; // applied codes, index 0 right
  logic [1:0]            soft_q;     // applied code is all zeros
  logic [TIMER_BITS-1:0] zc_tmr_q;   // level-change timeout timer
  logic [TIMER_BITS-1:0] hm_tmr_q;   // hard mute timeout timer
  logic                  hm_q;       // outputs grounded
  logic [TIMER_BITS-1:0] cal_tmr_q;  // calibration timer
  logic                  cal_q;      // calibration status, a flop so the pin never glitches

  // saturating increment shared by all timers
  function automatic logic [TIMER_BITS-1:0] sat_inc(input logic [TIMER_BITS-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // one bank of synchronisers for every pin from outside this clock except zero-cross enable
  sync_edge #(
    .WIDTH     (7),
    .RESET_VAL (DEV_SYNC_RESET)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  ({left_zero_cross_in, right_zero_cross_in, supply_ok_in, link.mute_n,
                 link.serial_data_in, link.shift_clk, link.select_n}),
    .level_out (lvl),
    .rise_out  (rise),
    .fall_out  (fall)
  );

  assign sel_n      = lvl[0];
  assign sdi        = lvl[2];
  assign supply_ok  = lvl[4];
  assign zc_rise    = rise[6:5];
  assign zc_any     = |zc_rise;
  assign mute_req   = !lvl[3] || !supply_ok;
  assign shift_rise = rise[1] && !sel_n;
  assign shift_fall = fall[1] && !sel_n;
  assign latch      = rise[0];
  assign zc_expired = zc_tmr_q >= TIMER_BITS'(ZC_TIMEOUT_CYCLES);
  assign hm_expired = hm_tmr_q >= TIMER_BITS'(ZC_TIMEOUT_CYCLES);

  // zero-cross enable passes two flops like any pin; its edges are not needed
  sync_edge #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_ze_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (zero_cross_enable_in),
    .level_out (ze),
    .rise_out  (),
    .fall_out  ()
  );

  // power-up and calibration sequencing; cal_q follows every state move
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q   <= ST_CLEAR;
      cal_tmr_q <= '0;
      cal_q     <= 1'b1;
    end
    else if (rise[4])
    begin
      state_q   <= ST_CLEAR;
      cal_tmr_q <= '0;
      cal_q     <= 1'b1;
    end
    else if (fall[3] && state_q == ST_RUN)
    begin
      state_q   <= ST_CAL;
      cal_tmr_q <= '0;
      cal_q     <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ST_CLEAR:
        begin
          state_q   <= ST_CAL;
          cal_tmr_q <= '0;
        end
        ST_CAL:
        begin
          cal_tmr_q <= sat_inc(cal_tmr_q);
          if (cal_tmr_q >= TIMER_BITS'(CAL_CYCLES - 1))
          begin
            state_q <= ST_RUN;
            cal_q   <= 1'b0;
          end
        end
        ST_RUN:
          cal_tmr_q <= '0;
      endcase
    end
  end

  // serial shift path and volume register
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shift_q <= WORD_RESET;
      vol_q   <= WORD_RESET;
    end
    else if (state_q == ST_CLEAR)
    begin
      shift_q <= WORD_RESET;
      vol_q   <= WORD_RESET;
    end
    else
    begin
      // msb first: right code ends up in the upper byte
      if (shift_rise)
      begin
        shift_q <= {shift_q[WORD_BITS-2:0], sdi};
      end
      if (latch)
      begin
        vol_q <= shift_q;
      end
    end
  end

  // serial output and its enable
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      oe_n_q <= sel_n;
      // frame start shows the oldest bit first
      // then each output edge shows the new tail
      if (fall[0] || shift_fall)
      begin
        sdo_q <= shift_q[WORD_BITS-1];
      end
    end
  end

  // per-channel level apply; a new latch restarts the wait
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend_q   <= 2'b00;
      zc_tmr_q <= '0;
      soft_q   <= 2'b11;
      for (int c = 0; c < 2; c++)
      begin
        zc_cnt_q[c] <= 2'h0;
        code_q[c]   <= SOFT_MUTE_CODE;
      end
    end
    else if (state_q == ST_CLEAR)
    begin
      pend_q   <= 2'b00;
      zc_tmr_q <= '0;
      soft_q   <= 2'b11;
      for (int c = 0; c < 2; c++)
      begin
        zc_cnt_q[c] <= 2'h0;
        code_q[c]   <= SOFT_MUTE_CODE;
      end
    end
    else if (latch)
    begin
      pend_q   <= 2'b11;
      zc_tmr_q <= '0;
      for (int c = 0; c < 2; c++)
      begin
        zc_cnt_q[c] <= 2'h0;
      end
    end
    else
    begin
      zc_tmr_q <= sat_inc(zc_tmr_q);
      for (int c = 0; c < 2; c++)
      begin
        if (pend_q[c])
        begin
          if (!ze || zc_cnt_q[c] >= ZC_NEEDED || zc_expired)
          begin
            pend_q[c] <= 1'b0;
            // code passed on unchanged, one step per half dB
            code_q[c] <= (c == 0) ? vol_q[RIGHT_MSB:RIGHT_LSB] : vol_q[LEFT_MSB:LEFT_LSB];
            soft_q[c] <= ((c == 0) ? vol_q[RIGHT_MSB:RIGHT_LSB]
                                   : vol_q[LEFT_MSB:LEFT_LSB]) == SOFT_MUTE_CODE;
          end
          else if (zc_rise[c])
          begin
            zc_cnt_q[c] <= zc_cnt_q[c] + 2'h1;
          end
        end
      end
    end
  end

  // hard mute: enters on a crossing or timeout, or at once with zero-cross off; leaves at once
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hm_q     <= 1'b1;
      hm_tmr_q <= '0;
    end
    else if (!mute_req)
    begin
      hm_q     <= 1'b0;
      hm_tmr_q <= '0;
    end
    else if (!hm_q)
    begin
      hm_tmr_q <= sat_inc(hm_tmr_q);
      // crossing, timeout or zero-cross disabled ends the wait
      if (!ze || zc_any || hm_expired)
      begin
        hm_q <= 1'b1;
      end
    end
  end

  // link and user-side outputs straight from flops
  assign link.serial_data_out      = sdo_q;
  assign link.serial_data_out_oe_n = oe_n_q;
  assign right_output_code_out     = code_q[0];
  assign left_output_code_out      = code_q[1];
  assign right_soft_mute_out       = soft_q[0];
  assign left_soft_mute_out        = soft_q[1];
  assign hard_mute_out             = hm_q;
  assign calibrating_out           = cal_q;
  assign volume_reg_out            = vol_q;
endmodule

//--- design/vol_ctrl_host.sv
// host end: drives 16-bit words out with readback, and the mute line
`timescale 1ns/100ps
module vol_ctrl_host
  import vol_ctrl_pkg::*;
#(
  parameter int unsigned MUTE_HOLD_CYCLES = MUTE_HOLD_CYC
) (
  // clock and reset
  input  wire logic   clock_in,
  input  wire logic   resetn_in,
  // serial link
  vol_link_if.host    link,
  // user command side
  input  wire logic        start_in,
  input  wire logic [15:0] word_in,
  input  wire logic        mute_req_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      readback_out
);
  host_state_t           st_q;      // transfer sequencing
  logic [DIV_BITS-1:0]   div_q;     // shift clock divider
  logic [4:0]            bit_q;     // bits sent in this word
  logic [15:0]           tx_q;      // outgoing word, msb first
  logic [15:0]           rx_q;      // readback collected
  logic                  sel_n_q;
  logic                  sclk_q;
  logic                  sdi_q;
  logic                  done_q;
  logic                  busy_q;    // transfer in progress, a flop for a clean pin
  logic                  mute_n_q;
  logic [TIMER_BITS-1:0] hold_q;    // mute low time so far
  logic                  sdo_s;
  logic                  half_done;

  // readback pin is from the device domain
  sync_edge #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_sdo_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (link.serial_data_out_level),
    .level_out (sdo_s),
    .rise_out  (),
    .fall_out  ()
  );

  assign half_done = div_q >= DIV_BITS'(SCLK_HALF_CYC - 1);

  // word transfer: select low, 16 clocks, select high, gap
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q    <= H_IDLE;
      div_q   <= '0;
      bit_q   <= BIT_COUNT_RESET;
      tx_q    <= WORD_RESET;
      rx_q    <= WORD_RESET;
      sel_n_q <= 1'b1;
      sclk_q  <= 1'b0;
      sdi_q   <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      div_q  <= half_done ? '0 : div_q + 1'b1;
      unique case (st_q)
        H_IDLE:
        begin
          div_q <= '0;
          if (start_in)
          begin
            // lower select before the first bit
            st_q    <= H_LEAD;
            sel_n_q <= 1'b0;
            busy_q  <= 1'b1;
            tx_q    <= word_in;
            bit_q   <= BIT_COUNT_RESET;
          end
        end
        // first bit sent is the right code msb
        H_LEAD, H_LOW:
        begin
          sdi_q <= tx_q[WORD_BITS-1];
          if (half_done)
          begin
            st_q   <= H_HIGH;
            sclk_q <= 1'b1;
          end
        end
        H_HIGH:
        begin
          if (half_done)
          begin
            // sample readback late in the high phase, well after the device fall
            rx_q   <= {rx_q[WORD_BITS-2:0], sdo_s};
            tx_q   <= {tx_q[WORD_BITS-2:0], 1'b0};
            sclk_q <= 1'b0;
            bit_q  <= bit_q + 5'h01;
            st_q   <= (bit_q == 5'(WORD_BITS - 1)) ? H_TAIL : H_LOW;
          end
        end
        H_TAIL:
        begin
          if (half_done)
          begin
            st_q    <= H_GAP;
            sel_n_q <= 1'b1;
          end
        end
        H_GAP:
        begin
          if (half_done)
          begin
            st_q   <= H_IDLE;
            done_q <= 1'b1;
            busy_q <= 1'b0;
          end
        end
        default:
        begin
          st_q   <= H_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // mute line; once lowered it stays low for at least the mute hold time
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mute_n_q <= 1'b0;
      hold_q   <= '0;
    end
    else if (!mute_n_q)
    begin
      hold_q <= (&hold_q) ? hold_q : hold_q + 1'b1;
      // at least the minimum low time
      if (!mute_req_in && hold_q >= TIMER_BITS'(MUTE_HOLD_CYCLES - 1))
      begin
        mute_n_q <= 1'b1;
      end
    end
    else if (mute_req_in)
    begin
      mute_n_q <= 1'b0;
      hold_q   <= '0;
    end
  end

  assign link.select_n       = sel_n_q;
  assign link.shift_clk      = sclk_q;
  assign link.serial_data_in = sdi_q;
  assign link.mute_n         = mute_n_q;
  assign busy_out            = busy_q;
  assign done_out            = done_q;
  assign readback_out        = rx_q;
endmodule

//--- bench/vol_link_asserts.sv
// concurrent checks on the serial volume link between host and device
`timescale 1ns/100ps
module vol_link_asserts
  import vol_ctrl_pkg::*;
#(
  parameter int unsigned MUTE_HOLD_CYCLES = MUTE_HOLD_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // link wires
  input wire logic select_n,
  input wire logic shift_clk,
  input wire logic serial_data_in,
  input wire logic mute_n,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n
);
  logic [15:0]           shadow_q;  // model of the device shift path
  logic [4:0]            rises_q;   // shift clock rises in this frame
  logic [TIMER_BITS-1:0] low_q;     // cycles the mute line has been low

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  // shadow path: pin level is sampled, device lags but keeps the order
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      shadow_q <= WORD_RESET;
    else if (!select_n && $rose(shift_clk))
      shadow_q <= {shadow_q[14:0], serial_data_in};
  end

  // rise counter, cleared at each frame start
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rises_q <= BIT_COUNT_RESET;
    else if ($fell(select_n))
      rises_q <= BIT_COUNT_RESET;
    else if (!select_n && $rose(shift_clk))
      rises_q <= rises_q + 5'h01;
  end

  // mute low time; wraps only far beyond any hold in use
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      low_q <= '0;
    else if (!mute_n)
      low_q <= low_q + 1'b1;
    else
      low_q <= '0;
  end

  oe_released_a: assert property (select_n [*6] |-> serial_data_out_oe_n)
    else $error("data out driven while select high");
  oe_driven_a: assert property ((!select_n) [*6] |-> !serial_data_out_oe_n)
    else $error("data out not driven in frame");
  sdo_hold_a: assert property ((!select_n && shift_clk) [*4] |-> $stable(serial_data_out))
    else $error("data out moved while shift clock high");
  sdo_tail_a: assert property ((!select_n && !shift_clk) [*6] |-> serial_data_out == shadow_q[15])
    else $error("data out is not the shift path tail");
  sdi_stable_a: assert property (!select_n && shift_clk |-> $stable(serial_data_in))
    else $error("data in moved while shift clock high");
  sclk_high_a: assert property ($rose(shift_clk) |-> shift_clk [*8])
    else $error("shift clock high phase too short");
  lead_time_a: assert property ($fell(select_n) |-> (!shift_clk) [*8])
    else $error("shift clock too soon after select fall");
  idle_clock_a: assert property (select_n |-> !shift_clk)
    else $error("shift clock high outside a frame");
  word_len_a: assert property ($rose(select_n) |-> rises_q == 5'h10)
    else $error("frame did not carry sixteen bits");
  mute_hold_a: assert property ($rose(mute_n) |-> low_q >= MUTE_HOLD_CYCLES - 1)
    else $error("mute line released too early");

  // main scenarios reached
  frame_c: cover property ($rose(select_n) && rises_q == 5'h10);
  unmute_c: cover property ($rose(mute_n));
  drive_c: cover property ($fell(serial_data_out_oe_n));
endmodule

//--- bench/stereo_volume_serial_mute_ctrl_tb.sv
// self-checking bench: host and device joined over the serial link
`timescale 1ns/100ps
module stereo_volume_serial_mute_ctrl_tb;
  import vol_ctrl_pkg::*;
  localparam int unsigned ZC_TO = 200;  // shortened crossing timeout
  localparam int unsigned CAL   = 50;   // shortened calibration
  localparam int unsigned HOLD  = 60;   // shortened mute hold
  // one table row: word sent and levels it should apply
  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  right;
    logic [7:0]  left;
  } row_t;
  logic        clock_in              = 1'b0;
  logic        resetn_in             = 1'b0;
  logic        start_in              = 1'b0;
  logic [15:0] word_in               = 16'h0000;
  logic        mute_req_in           = 1'b0;
  logic        zero_cross_enable_in  = 1'b0;
  logic        left_zero_cross_in    = 1'b0;
  logic        right_zero_cross_in   = 1'b0;
  logic        supply_ok_in          = 1'b1;
  logic        busy_out;
  logic        done_out;
  logic [15:0] readback_out;
  logic [7:0]  left_output_code_out;
  logic [7:0]  right_output_code_out;
  logic        left_soft_mute_out;
  logic        right_soft_mute_out;
  logic        hard_mute_out;
  logic        calibrating_out;
  logic [15:0] volume_reg_out;
  logic [15:0] prev;                 // word the device should hand back
  int          n_errors              = 0;
  int          checked               = 0;
  // zero code rows exercise software mute on each channel
  row_t        rows[4]               = '{'{16'hC0C0, 8'hC0, 8'hC0}, '{16'h00FF, 8'h00, 8'hFF},
                                         '{16'hFF00, 8'hFF, 8'h00}, '{16'h0180, 8'h01, 8'h80}};

  vol_link_if link ();
  vol_ctrl_host #(.MUTE_HOLD_CYCLES(HOLD)) vol_ctrl_host_inst (.clock_in, .resetn_in,
    .link(link), .start_in, .word_in, .mute_req_in, .busy_out, .done_out, .readback_out);
  vol_ctrl_device #(.ZC_TIMEOUT_CYCLES(ZC_TO), .CAL_CYCLES(CAL)) vol_ctrl_device_inst (
    .clock_in, .resetn_in, .link(link), .zero_cross_enable_in, .left_zero_cross_in,
    .right_zero_cross_in, .supply_ok_in, .left_output_code_out, .right_output_code_out,
    .left_soft_mute_out, .right_soft_mute_out, .hard_mute_out, .calibrating_out,
    .volume_reg_out);
  vol_link_asserts #(.MUTE_HOLD_CYCLES(HOLD)) vol_link_asserts_inst (.clock_in(clock_in),
    .resetn_in(resetn_in), .select_n(link.select_n), .shift_clk(link.shift_clk),
    .serial_data_in(link.serial_data_in), .mute_n(link.mute_n),
    .serial_data_out(link.serial_data_out), .serial_data_out_oe_n(link.serial_data_out_oe_n));

  // free-running system clock
  always #2.5 clock_in = ~clock_in;

  // word and code comparison
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // flag comparison
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // applied levels and soft mute flags of both channels
  task automatic check_apply(input logic [7:0] r, input logic [7:0] l);
    cmp_val({8'h00, right_output_code_out}, {8'h00, r}, "right code");
    cmp_val({8'h00, left_output_code_out}, {8'h00, l}, "left code");
    cmp_bit(right_soft_mute_out, r == SOFT_MUTE_CODE, "right soft mute");
    cmp_bit(left_soft_mute_out, l == SOFT_MUTE_CODE, "left soft mute");
  endtask

  // one word through the host; bounded wait for its completion pulse
  task automatic send(input logic [15:0] w);
    int i;
    @(negedge clock_in);
    start_in = 1'b1;
    word_in  = w;
    @(negedge clock_in);
    start_in = 1'b0;
    cmp_bit(busy_out, 1'b1, "transfer busy");
    for (i = 0; i < 2000 && done_out !== 1'b1; i++)
      @(negedge clock_in);
    cmp_bit(done_out, 1'b1, "transfer done");
    cmp_bit(busy_out, 1'b0, "idle at done");
  endtask

  // one crossing pulse, held long enough for the synchroniser
  task automatic zc_pulse(input logic left);
    left_zero_cross_in  = left;
    right_zero_cross_in = !left;
    repeat (3) @(negedge clock_in);
    left_zero_cross_in  = 1'b0;
    right_zero_cross_in = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask

  // verdict, shared by the main sequence and the watchdog
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin : main_seq
    repeat (16) @(negedge clock_in);
    cmp_val(volume_reg_out, WORD_RESET, "reset volume");
    cmp_bit(hard_mute_out, 1'b1, "reset hard mute");
    cmp_bit(link.serial_data_out_level, 1'b1, "reset released");
    resetn_in = 1'b1;
    repeat (CAL + 80) @(negedge clock_in);
    cmp_bit(calibrating_out, 1'b0, "power-up cal over");
    cmp_bit(hard_mute_out, 1'b0, "unmuted");
    $display("reset test done");
    // table rows with crossing wait bypassed; readback is the previous word
    prev = WORD_RESET;
    foreach (rows[i])
    begin
      send(rows[i].word);
      cmp_val(volume_reg_out, rows[i].word, "latched word");
      cmp_val(readback_out, prev, "readback");
      check_apply(rows[i].right, rows[i].left);
      if (rows[i].word == {UNITY_CODE, UNITY_CODE})
        cmp_val({8'h00, right_output_code_out}, {8'h00, UNITY_CODE}, "unity code");
      prev = rows[i].word;
      $display("row %0d done", i);
    end
    // soft ramp down from the last row to the all-zero code
    send(16'h0040);
    check_apply(8'h00, 8'h40);
    send(WORD_RESET);
    check_apply(8'h00, 8'h00);
    $display("ramp test done");
    // crossing wait: one crossing is not enough, two apply, timeout for the other
    zero_cross_enable_in = 1'b1;
    send(16'h4050);
    check_apply(8'h00, 8'h00);
    zc_pulse(1'b0);
    check_apply(8'h00, 8'h00);
    zc_pulse(1'b0);
    check_apply(8'h40, 8'h00);
    repeat (ZC_TO) @(negedge clock_in);
    check_apply(8'h40, 8'h50);
    $display("crossing test done");
    // hard mute waits for a crossing and starts calibration
    mute_req_in = 1'b1;
    repeat (10) @(negedge clock_in);
    cmp_bit(hard_mute_out, 1'b0, "mute waits for crossing");
    cmp_bit(calibrating_out, 1'b1, "mute starts cal");
    zc_pulse(1'b1);
    cmp_bit(hard_mute_out, 1'b1, "mute at crossing");
    repeat (CAL + 10) @(negedge clock_in);
    cmp_bit(calibrating_out, 1'b0, "cal ends without shift clock");
    mute_req_in = 1'b0;
    repeat (HOLD + 10) @(negedge clock_in);
    cmp_bit(hard_mute_out, 1'b0, "mute released");
    cmp_val(volume_reg_out, 16'h4050, "volume kept");
    $display("mute test done");
    // supply loss mutes at once with wait bypassed, restore reruns power-up
    zero_cross_enable_in = 1'b0;
    supply_ok_in         = 1'b0;
    repeat (10) @(negedge clock_in);
    cmp_bit(hard_mute_out, 1'b1, "supply loss mute");
    supply_ok_in = 1'b1;
    repeat (10) @(negedge clock_in);
    cmp_bit(calibrating_out, 1'b1, "restore calibrates");
    cmp_val(volume_reg_out, WORD_RESET, "restore clears");
    check_apply(8'h00, 8'h00);
    $display("supply test done");
    close_out();
  end

  // hang guard, well beyond the expected run length
  initial
  begin : watchdog
    repeat (20000) @(posedge clock_in);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule
